/* pkg/pmwc_regs.vh */
/*
 Register map, field positions, state codes and timing counts of the
 power mode and wake-up controller. Assumes plain inclusion by bare name.
*/
`ifndef PMWC_REGS_VH
`define PMWC_REGS_VH
// byte addresses on the register bus
`define PMWC_A_MODE   5'h00
`define PMWC_A_CTRL   5'h04
`define PMWC_A_STAT   5'h08
`define PMWC_A_PORTA_WAKE_ENABLE   5'h0C
`define PMWC_A_PORTX_WAKE_ENABLE   5'h10
// mode_control_reg fields
`define PMWC_F_FCS    0
`define PMWC_F_IDLE   1
`define PMWC_F_FRDY   2
`define PMWC_F_SRDY   3
`define PMWC_F_FAST_WAKE_ENABLE  4
`define PMWC_F_XTAL   5
`define PMWC_F_DIV_LO 6
`define PMWC_F_DIV_HI 8
// ctrl and status fields
`define PMWC_F_SYSIDL 7
`define PMWC_F_PDF    0
`define PMWC_F_TO     1
`define PMWC_F_ST_LO  4
`define PMWC_F_ST_HI  6
// reset values
`define PMWC_RST_MODE 9'h001
`define PMWC_RST_DIV  3'h0
// divider codes that select the slow clock
`define PMWC_DIV_SLOW 2'h0
// bus responses
`define PMWC_OKAY     2'h0
`define PMWC_SLVERR   2'h2
// operating states
`define PMWC_S_RUN    3'h0
`define PMWC_S_DEEP   3'h1
`define PMWC_S_WATCH  3'h2
`define PMWC_S_CGIDL  3'h3
`define PMWC_S_RIDL   3'h4
`define PMWC_S_WAKE   3'h5
// oscillator settling, in oscillator cycles
`define PMWC_FAST_CYC 11'h400
`define PMWC_SLOW_CYC 2'h2
`endif

/* hw/pmwc_top.v */
/*
 Power mode and wake-up controller: normal/slow clock selection, the four
 halt states, wake-up sources and the power-down and time-out flags.
 Assumes the oscillators, watchdog counter, interrupt controller and CPU
 sit outside; oscillator ticks and pins arrive asynchronous to clk_sys.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pmwc_regs.vh"

// Summary of operation
// - slow mode when fast select clear, div 000/001
// - normal mode on fast select or div 010-111
// - slow clock stops fast source and div clocks
// - slow switch waits for slow oscillator ready flag
// - halt, no idle, no wdt/lvd: deep sleep
// - halt, no idle, wdt or lvd: watch sleep
// - halt, idle, no sysclock: clock gated idle
// - halt, idle and sysclock: running idle
// - entry keeps state, sets powerdown, clears timeout
// - wake on reset, port edges, interrupt, overflow
// - reset wake full reset, overflow watchdog reset
// - powerdown cleared by powerup/clear wdt, set halt
// - sleeping timeout sets flag, resets pc and sp
// - enabled pin wakes, resumes after halt
// - disabled or stack full irq resumes after halt
// - enabled irq with free stack gets serviced
// - irq already pending at halt cannot wake
// - fast ready after 1024 fast oscillator cycles
// - crystal fast wake runs slow until ready
module pmwc_top #(
  parameter PA_W  = 8,
  parameter PX_W  = 31,
  parameter IRQ_W = 8
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst_n,
  // axi4-lite slave
  input  wire [4:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [4:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // cpu side events, same clock
  input  wire             halt_exec,
  input  wire             clr_wdt_exec,
  input  wire             wdt_on,
  input  wire             lvd_on,
  input  wire             wdt_overflow,
  input  wire [IRQ_W-1:0] irq_req,
  input  wire [IRQ_W-1:0] irq_enabled,
  input  wire             stack_full,
  // asynchronous inputs
  input  wire             fast_osc_tick,
  input  wire             slow_osc_tick,
  input  wire             ext_reset_req,
  input  wire             usb_reset_req,
  input  wire [PA_W-1:0]  porta_pin,
  input  wire [PX_W-1:0]  portx_pin,
  // clock and core control
  output reg              fast_osc_en,
  output reg              sysclk_from_slow,
  output reg              sys_clk_run,
  output reg              sub_clk_run,
  output reg              cpu_run,
  output reg              wdt_clear,
  output reg              wdt_hold,
  output reg              full_reset,
  output reg              wdt_reset,
  output reg              resume_after_halt,
  output reg              irq_take
);

  localparam SW = PA_W + PX_W + 4;
  localparam [8:0] RST_MODE = `PMWC_RST_MODE;

  // software state
  reg              fast_clock_select;
  reg [2:0]        divider_select;
  reg              idle_on_halt;
  reg              fast_wake_enable;
  reg              osc_is_crystal;
  reg              sysclock_in_idle;
  reg [PA_W-1:0]   porta_wake_enable;
  reg [PX_W-1:0]   portx_wake_enable;
  reg              powerdown_flag;
  reg              timeout_flag;
  reg              fast_osc_ready;
  reg              slow_osc_ready;
  reg [2:0]        state;
  reg              fast_wake_run;
  reg [IRQ_W-1:0]  irq_blocked;
  reg [10:0]       fast_cnt;
  reg [1:0]        slow_cnt;
  // synchronisers: stage 1 feeds only stage 2
  reg [SW-1:0]     sync1;
  reg [SW-1:0]     sync2;
  reg [SW-1:0]     sync3;
  reg [31:0]       rd_word;

  wire [PA_W-1:0]  pa_now  = sync2[PA_W-1:0];
  wire [PA_W-1:0]  pa_old  = sync3[PA_W-1:0];
  wire [PX_W-1:0]  px_now  = sync2[PA_W+PX_W-1:PA_W];
  wire [PX_W-1:0]  px_old  = sync3[PA_W+PX_W-1:PA_W];
  wire             ftick   = sync2[SW-4] & ~sync3[SW-4];
  wire             stick   = sync2[SW-3] & ~sync3[SW-3];
  wire             rst_req = sync2[SW-2] | sync2[SW-1];

  // halt state from the three selecting conditions
  function [2:0] halt_target;
    input idl;
    input sys;
    input sub;
    begin
      if (!idl)
        halt_target = sub ? `PMWC_S_WATCH : `PMWC_S_DEEP;
      else
        halt_target = sys ? `PMWC_S_RIDL : `PMWC_S_CGIDL;
    end
  endfunction

  wire slow_req   = ~fast_clock_select &
                    (divider_select[2:1] == `PMWC_DIV_SLOW);
  wire pin_wake   = |(porta_wake_enable & (pa_now ^ pa_old)) |
                    |(portx_wake_enable & ~px_now & px_old);
  wire [IRQ_W-1:0] irq_live = irq_req & ~irq_blocked;
  wire irq_wake   = |irq_live;
  wire irq_serve  = |(irq_live & irq_enabled) & ~stack_full;
  wire fast_stop  = (state == `PMWC_S_DEEP) | (state == `PMWC_S_WATCH) |
                    (state == `PMWC_S_CGIDL) | slow_req;
  wire slow_alive = (state != `PMWC_S_DEEP) | wdt_on | lvd_on;
  wire wr_go      = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;

  // two flip-flops on every pin and oscillator tick, third for edges
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= {SW{1'b0}};
      sync2 <= {SW{1'b0}};
      sync3 <= {SW{1'b0}};
    end else begin
      sync1 <= {usb_reset_req, ext_reset_req, slow_osc_tick, fast_osc_tick,
                portx_pin, porta_pin};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // oscillator ready counters; cleared whenever the source is stopped
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt       <= 11'h000;
      fast_osc_ready <= 1'b0;
      slow_cnt       <= 2'h0;
      slow_osc_ready <= 1'b0;
    end else begin
      if (fast_stop) begin
        fast_cnt       <= 11'h000;
        fast_osc_ready <= 1'b0;
      end else if (ftick && !fast_osc_ready) begin
        fast_cnt <= fast_cnt + 11'h001;
        if (fast_cnt == `PMWC_FAST_CYC - 11'h001)
          fast_osc_ready <= 1'b1;
      end
      if (!slow_alive) begin
        slow_cnt       <= 2'h0;
        slow_osc_ready <= 1'b0;
      end else if (stick && !slow_osc_ready) begin
        slow_cnt <= slow_cnt + 2'h1;
        if (slow_cnt == `PMWC_SLOW_CYC - 2'h1)
          slow_osc_ready <= 1'b1;
      end
    end
  end

  // mode sequencer, flags and wake actions
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state             <= `PMWC_S_RUN;
      powerdown_flag    <= 1'b0;
      timeout_flag      <= 1'b0;
      fast_wake_run     <= 1'b0;
      irq_blocked       <= {IRQ_W{1'b0}};
      wdt_clear         <= 1'b0;
      full_reset        <= 1'b0;
      wdt_reset         <= 1'b0;
      resume_after_halt <= 1'b0;
      irq_take          <= 1'b0;
    end else begin
      wdt_clear         <= 1'b0;
      full_reset        <= 1'b0;
      wdt_reset         <= 1'b0;
      resume_after_halt <= 1'b0;
      irq_take          <= 1'b0;
      if (clr_wdt_exec)
        powerdown_flag <= 1'b0;
      case (state)
        `PMWC_S_RUN: begin
          if (halt_exec) begin
            state          <= halt_target(idle_on_halt, sysclock_in_idle,
                                          wdt_on | lvd_on);
            powerdown_flag <= 1'b1;
            timeout_flag   <= 1'b0;
            wdt_clear      <= 1'b1;
            irq_blocked    <= irq_req;
          end
        end
        `PMWC_S_DEEP, `PMWC_S_WATCH, `PMWC_S_CGIDL, `PMWC_S_RIDL: begin
          // reset beats overflow beats pins and interrupts
          if (rst_req) begin
            full_reset     <= 1'b1;
            powerdown_flag <= 1'b0;
            timeout_flag   <= 1'b0;
            state          <= `PMWC_S_WAKE;
          end else if (wdt_overflow && wdt_on) begin
            wdt_reset    <= 1'b1;
            timeout_flag <= 1'b1;
            state        <= `PMWC_S_WAKE;
          end else if (pin_wake) begin
            resume_after_halt <= 1'b1;
            state             <= `PMWC_S_WAKE;
          end else if (irq_wake) begin
            irq_take          <= irq_serve;
            resume_after_halt <= ~irq_serve;
            state             <= `PMWC_S_WAKE;
          end
          if (rst_req | (wdt_overflow & wdt_on) | pin_wake | irq_wake)
            fast_wake_run <= osc_is_crystal & fast_wake_enable &
                             ((state == `PMWC_S_WATCH) |
                              (state == `PMWC_S_CGIDL));
        end
        `PMWC_S_WAKE: begin
          // leave once the fast oscillator is ready, or at once when slow mode is selected
          if (fast_osc_ready | slow_req) begin
            state         <= `PMWC_S_RUN;
            fast_wake_run <= 1'b0;
          end
        end
        default: state <= `PMWC_S_RUN;
      endcase
    end
  end

  // clock and core enables; outputs straight from flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_osc_en      <= 1'b1;
      sysclk_from_slow <= 1'b0;
      sys_clk_run      <= 1'b1;
      sub_clk_run      <= 1'b1;
      cpu_run          <= 1'b0;
      wdt_hold         <= 1'b0;
    end else begin
      fast_osc_en      <= ~fast_stop;
      sysclk_from_slow <= (slow_req & slow_osc_ready) |
                          fast_wake_run;
      sys_clk_run      <= (state == `PMWC_S_RUN) | (state == `PMWC_S_RIDL) |
                          (state == `PMWC_S_WAKE);
      sub_clk_run      <= slow_alive;
      cpu_run          <= ((state == `PMWC_S_RUN) & ~halt_exec) |
                          ((state == `PMWC_S_WAKE) & fast_wake_run);
      wdt_hold         <= (state == `PMWC_S_DEEP);
    end
  end

  // read mux
  always @* begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `PMWC_A_MODE: begin
        rd_word[`PMWC_F_FCS]    = fast_clock_select;
        rd_word[`PMWC_F_IDLE]   = idle_on_halt;
        rd_word[`PMWC_F_FRDY]   = fast_osc_ready;
        rd_word[`PMWC_F_SRDY]   = slow_osc_ready;
        rd_word[`PMWC_F_FAST_WAKE_ENABLE]  = fast_wake_enable;
        rd_word[`PMWC_F_XTAL]   = osc_is_crystal;
        rd_word[`PMWC_F_DIV_HI:`PMWC_F_DIV_LO] = divider_select;
      end
      `PMWC_A_CTRL: rd_word[`PMWC_F_SYSIDL] = sysclock_in_idle;
      `PMWC_A_STAT: begin
        rd_word[`PMWC_F_PDF] = powerdown_flag;
        rd_word[`PMWC_F_TO]  = timeout_flag;
        rd_word[`PMWC_F_ST_HI:`PMWC_F_ST_LO] = state;
      end
      `PMWC_A_PORTA_WAKE_ENABLE: rd_word[PA_W-1:0] = porta_wake_enable;
      `PMWC_A_PORTX_WAKE_ENABLE: rd_word[PX_W-1:0] = portx_wake_enable;
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  // write channel: address and data taken together, answer next cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= `PMWC_OKAY;
      fast_clock_select <= RST_MODE[`PMWC_F_FCS];
      divider_select    <= `PMWC_RST_DIV;
      idle_on_halt      <= 1'b0;
      fast_wake_enable  <= 1'b0;
      osc_is_crystal    <= 1'b0;
      sysclock_in_idle  <= 1'b0;
      porta_wake_enable <= {PA_W{1'b0}};
      portx_wake_enable <= {PX_W{1'b0}};
    end else begin
      s_axi_awready <= wr_go & ~s_axi_awready;
      s_axi_wready  <= wr_go & ~s_axi_awready;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PMWC_OKAY;
        case (s_axi_awaddr)
          `PMWC_A_MODE: if (s_axi_wstrb[0] | s_axi_wstrb[1]) begin
            fast_clock_select <= s_axi_wdata[`PMWC_F_FCS];
            idle_on_halt      <= s_axi_wdata[`PMWC_F_IDLE];
            fast_wake_enable  <= s_axi_wdata[`PMWC_F_FAST_WAKE_ENABLE];
            osc_is_crystal    <= s_axi_wdata[`PMWC_F_XTAL];
            divider_select    <= s_axi_wdata[`PMWC_F_DIV_HI:`PMWC_F_DIV_LO];
          end
          `PMWC_A_CTRL: if (s_axi_wstrb[0])
            sysclock_in_idle <= s_axi_wdata[`PMWC_F_SYSIDL];
          `PMWC_A_STAT: ;
          `PMWC_A_PORTA_WAKE_ENABLE: porta_wake_enable <= s_axi_wdata[PA_W-1:0];
          `PMWC_A_PORTX_WAKE_ENABLE: portx_wake_enable <= s_axi_wdata[PX_W-1:0];
          default: s_axi_bresp <= `PMWC_SLVERR;
        endcase
      end
    end
  end

  // read channel: one cycle to arready, data the cycle after
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PMWC_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (s_axi_araddr > `PMWC_A_PORTX_WAKE_ENABLE ||
                         s_axi_araddr[1:0] != 2'h0) ? `PMWC_SLVERR : `PMWC_OKAY;
      end
    end
  end

endmodule

/* sim/pmwc_props.sv */
/*
 Concurrent checks on the power mode and wake-up controller ports.
 Assumes one clock domain, clk_sys, with rst_n as asynchronous active-low reset.
*/
`timescale 1ns/1ps
module pmwc_props #(
  parameter IRQ_W = 8
) (
  // clock and reset
  input wire             clk_sys,
  input wire             rst_n,
  // cpu side events
  input wire             halt_exec,
  input wire             wdt_overflow,
  input wire [IRQ_W-1:0] irq_req,
  input wire [IRQ_W-1:0] irq_enabled,
  input wire             stack_full,
  // clock and core control
  input wire             fast_osc_en,
  input wire             sysclk_from_slow,
  input wire             sys_clk_run,
  input wire             sub_clk_run,
  input wire             cpu_run,
  input wire             wdt_clear,
  input wire             wdt_hold,
  input wire             full_reset,
  input wire             wdt_reset,
  input wire             resume_after_halt,
  input wire             irq_take
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // slow clock right after a wake pulse is a fast wake: the crystal must keep settling then
  reg woke_d;
  reg fast_wake_seen;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      woke_d         <= 1'b0;
      fast_wake_seen <= 1'b0;
    end else begin
      woke_d         <= irq_take | resume_after_halt | wdt_reset | full_reset;
      fast_wake_seen <= (woke_d | fast_wake_seen) & sysclk_from_slow;
    end
  end

  // one cycle of grace so a switch in flight is not flagged
  slow_stops_fast_a: assert property ((sysclk_from_slow && !fast_wake_seen) [*2] |-> !fast_osc_en)
    else $error("fast source left running in slow mode");
  halt_clears_wdt_a: assert property (halt_exec && cpu_run |=> wdt_clear)
    else $error("halt did not clear the watchdog");
  clear_one_cycle_a: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear longer than one cycle");
  deep_stops_all_a: assert property (wdt_hold [*2] |-> !sys_clk_run && !sub_clk_run)
    else $error("clock running in deep sleep");
  cpu_needs_clk_a: assert property (!sys_clk_run |-> !cpu_run)
    else $error("cpu runs without system clock");
  overflow_wake_a: assert property (wdt_reset |-> $past(wdt_overflow) || $past(wdt_overflow, 2))
    else $error("watchdog reset without overflow");
  irq_service_a: assert property (irq_take |-> $past(|(irq_req & irq_enabled)) && !$past(stack_full))
    else $error("interrupt taken while disabled or stack full");
  resume_or_take_a: assert property (!(irq_take && resume_after_halt))
    else $error("resume and interrupt response together");
  resume_pulse_a: assert property (resume_after_halt |=> !resume_after_halt)
    else $error("resume pulse longer than one cycle");
  reset_pulse_a: assert property (full_reset |=> !full_reset)
    else $error("full reset pulse longer than one cycle");
endmodule

bind pmwc_top pmwc_props #(.IRQ_W(IRQ_W)) u_props (.clk_sys(clk_sys), .rst_n(rst_n), .halt_exec(halt_exec),
  .wdt_overflow(wdt_overflow), .irq_req(irq_req), .irq_enabled(irq_enabled), .stack_full(stack_full),
  .fast_osc_en(fast_osc_en), .sysclk_from_slow(sysclk_from_slow), .sys_clk_run(sys_clk_run),
  .sub_clk_run(sub_clk_run), .cpu_run(cpu_run), .wdt_clear(wdt_clear), .wdt_hold(wdt_hold),
  .full_reset(full_reset), .wdt_reset(wdt_reset), .resume_after_halt(resume_after_halt), .irq_take(irq_take));

/* sim/tb_top.sv */
/*
 Self-checking bench for the power mode and wake-up controller.
 Assumes the register map header on the include path; oscillators are
 modelled as tick waveforms slower than clk_sys/3.
*/
`timescale 1ns/1ps
`include "pmwc_regs.vh"
module tb_top;
  reg         clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [4:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd, v;
  reg  [3:0]  s_axi_wstrb;
  reg         halt_exec, clr_wdt_exec, wdt_on, lvd_on, wdt_overflow, stack_full;
  reg  [7:0]  irq_req, irq_enabled, porta_pin;
  reg  [30:0] portx_pin;
  reg         fast_osc_tick, slow_osc_tick, ext_reset_req, usb_reset_req;
  reg  [1:0]  rs;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        fast_osc_en, sysclk_from_slow, sys_clk_run, sub_clk_run, cpu_run, wdt_clear, wdt_hold;
  wire        full_reset, wdt_reset, resume_after_halt, irq_take;
  integer     failures, comparisons, cyc, n_clr, n_full, n_wdr, n_res, n_take, k;

  pmwc_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec), .wdt_on(wdt_on), .lvd_on(lvd_on),
    .wdt_overflow(wdt_overflow), .irq_req(irq_req), .irq_enabled(irq_enabled), .stack_full(stack_full),
    .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick), .ext_reset_req(ext_reset_req),
    .usb_reset_req(usb_reset_req), .porta_pin(porta_pin), .portx_pin(portx_pin), .fast_osc_en(fast_osc_en),
    .sysclk_from_slow(sysclk_from_slow), .sys_clk_run(sys_clk_run), .sub_clk_run(sub_clk_run),
    .cpu_run(cpu_run), .wdt_clear(wdt_clear), .wdt_hold(wdt_hold), .full_reset(full_reset),
    .wdt_reset(wdt_reset), .resume_after_halt(resume_after_halt), .irq_take(irq_take));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // oscillator ticks, wake pulse tallies and the hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    fast_osc_tick <= cyc[1];
    slow_osc_tick <= cyc[4];
    n_clr <= n_clr + wdt_clear;
    n_full <= n_full + full_reset;
    n_wdr <= n_wdr + wdt_reset;
    n_res <= n_res + resume_after_halt;
    n_take <= n_take + irq_take;
    if (cyc == 80000) begin
      failures = failures + 1;
      report_and_stop;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // aw and w offered together, each dropped once its own ready is seen
  task wr(input [4:0] a, input [31:0] d);
    reg ga, gw;
    begin
      ga = 1'b0;
      gw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ga && gw)) begin
        @(posedge clk_sys);
        if (s_axi_awready) begin
          ga = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wready) begin
          gw = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (!s_axi_bvalid) @(posedge clk_sys);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
      @(posedge clk_sys);
    end
  endtask

  task rdr(input [4:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk_sys);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk_sys);
    end
  endtask

  task halt;
    begin
      halt_exec <= 1'b1;
      @(posedge clk_sys);
      halt_exec <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  task wait_run;
    begin
      repeat (12) @(posedge clk_sys);
      do rdr(`PMWC_A_STAT); while (rd[6:4] !== `PMWC_S_RUN);
    end
  endtask

  // expected halt target for table row i
  function [2:0] exp_state(input integer i);
    exp_state = (i == 0) ? `PMWC_S_DEEP : (i == 1) ? `PMWC_S_WATCH : (i == 2) ? `PMWC_S_CGIDL : `PMWC_S_RIDL;
  endfunction

  task report_and_stop;
    begin
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  initial begin
    {failures, comparisons, cyc, n_clr, n_full, n_wdr, n_res, n_take} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rst_n} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, halt_exec, clr_wdt_exec, wdt_on, lvd_on} = 0;
    {wdt_overflow, stack_full, irq_req, irq_enabled, porta_pin, portx_pin} = 0;
    {fast_osc_tick, slow_osc_tick, ext_reset_req, usb_reset_req} = 0;
    s_axi_wstrb = 4'hF;
    v = $urandom(86814);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdr(`PMWC_A_MODE);
    chk({rd[8:6], rd[0]}, 32'h1);
    do rdr(`PMWC_A_MODE); while (rd[2] !== 1'b1);
    rdr(5'h14);
    chk(rs, `PMWC_SLVERR);
    v = $urandom;
    wr(`PMWC_A_PORTA_WAKE_ENABLE, v);
    chk(rs, `PMWC_OKAY);
    wr(5'h14, v);
    chk(rs, `PMWC_SLVERR);
    rdr(`PMWC_A_PORTA_WAKE_ENABLE);
    chk(rd[7:0], v[7:0]);
    // each halt target, woken by a random interrupt; row 2 has a full stack
    for (k = 0; k < 4; k = k + 1) begin
      lvd_on <= (k == 1);
      stack_full <= (k == 2);
      wr(`PMWC_A_MODE, {30'h0, k[1], 1'b1});
      wr(`PMWC_A_CTRL, (k == 3) ? 32'h80 : 32'h0);
      halt;
      chk(n_clr, k + 1);
      rdr(`PMWC_A_STAT);
      chk({rd[6:4], rd[1:0]}, {exp_state(k), 2'b01});
      chk({sys_clk_run, sub_clk_run, cpu_run, wdt_hold}, {k == 3, k != 0, 1'b0, k == 0});
      irq_enabled <= 8'hFF;
      irq_req <= 8'h01 << ($urandom % 8);
      wait_run;
      irq_req <= 8'h00;
      chk(n_take, (k < 2) ? k + 1 : k);
      chk(n_res, k >= 2);
    end
    // an interrupt pending at halt and a disabled pin must not wake
    stack_full <= 1'b0;
    lvd_on <= 1'b0;
    wr(`PMWC_A_PORTA_WAKE_ENABLE, 32'h1);
    wr(`PMWC_A_MODE, 32'h3);
    wr(`PMWC_A_CTRL, 32'h0);
    irq_req <= 8'h04;
    halt;
    porta_pin <= 8'h02;
    repeat (20) @(posedge clk_sys);
    rdr(`PMWC_A_STAT);
    chk(rd[6:4], `PMWC_S_CGIDL);
    irq_req <= 8'h00;
    porta_pin <= 8'h03;
    wait_run;
    chk(n_res, 2);
    // ports b to e wake on a falling edge only, a rising one is ignored
    wr(`PMWC_A_PORTX_WAKE_ENABLE, 32'h4);
    halt;
    portx_pin <= 31'h4;
    repeat (20) @(posedge clk_sys);
    rdr(`PMWC_A_STAT);
    chk(rd[6:4], `PMWC_S_CGIDL);
    portx_pin <= 31'h0;
    wait_run;
    chk(n_res, 3);
    // watchdog overflow in watch sleep, then the clear instruction
    wr(`PMWC_A_MODE, 32'h1);
    wdt_on <= 1'b1;
    halt;
    wdt_overflow <= 1'b1;
    @(posedge clk_sys);
    wdt_overflow <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(n_wdr, 1);
    rdr(`PMWC_A_STAT);
    chk(rd[1:0], 2'b11);
    wait_run;
    clr_wdt_exec <= 1'b1;
    @(posedge clk_sys);
    clr_wdt_exec <= 1'b0;
    rdr(`PMWC_A_STAT);
    chk(rd[1:0], 2'b10);
    // external or usb reset wake clears both flags
    halt;
    {usb_reset_req, ext_reset_req} <= ($urandom % 2) ? 2'b10 : 2'b01;
    repeat (8) @(posedge clk_sys);
    {usb_reset_req, ext_reset_req} <= 2'b00;
    chk(n_full, 1);
    rdr(`PMWC_A_STAT);
    chk(rd[1:0], 2'b00);
    wdt_on <= 1'b0;
    wait_run;
    // slow mode with divider 0 or 1, then back to a fast divider
    wr(`PMWC_A_MODE, ($urandom % 2) << 6);
    k = 0;
    while (!sysclk_from_slow && k < 500) begin
      @(posedge clk_sys);
      k = k + 1;
    end
    repeat (3) @(posedge clk_sys);
    chk({sysclk_from_slow, fast_osc_en}, 2'b10);
    rdr(`PMWC_A_MODE);
    chk(rd[3], 1'b1);
    wr(`PMWC_A_MODE, (2 + $urandom % 6) << 6);
    rdr(`PMWC_A_MODE);
    chk({fast_osc_en, rd[2]}, 2'b10);
    do rdr(`PMWC_A_MODE); while (rd[2] !== 1'b1);
    chk(sysclk_from_slow, 1'b0);
    // crystal fast wake from watch sleep runs on the slow clock until ready
    wr(`PMWC_A_MODE, 32'h31);
    lvd_on <= 1'b1;
    halt;
    irq_req <= 8'h10;
    repeat (8) @(posedge clk_sys);
    chk({sysclk_from_slow, cpu_run, fast_osc_en}, 3'b111);
    wait_run;
    irq_req <= 8'h00;
    lvd_on <= 1'b0;
    chk(sysclk_from_slow, 1'b0);
    report_and_stop;
  end
endmodule
